// ### verilog/sfcrs_top.v
// Operation
// - Opcode 06H at a clean frame end sets the write latch flag
// - Status writes only execute with the write latch flag set or after 50H
// - Opcode 04H at a clean frame end clears the write latch flag
// - Write latch clears at reset and when a status write finishes
// - Reset loads the volatile status copy from the stored bits
// - 50H arms a volatile-only update for the command that directly follows
// - Status reads are served even while a write cycle runs
// - 05H streams status low byte, 35H high byte, repeating
// - 01H writes one or two bytes, 31H writes the high byte
// - Status write leaves all non-writable bits unchanged
// - Status write must end after exactly 8 data bits, or 8 or 16 for 01H
// - Frame end starts timed write; busy set, then both flags clear
// - Lock bit 7 plus protect pin block every status write
// - 03H takes three address bytes, then data leaves on falls
// - Read address increments per byte and wraps to zero
// - Select high ends a read and releases the outputs
// - Array reads are refused while a write cycle is busy
// - 0BH adds one dummy byte before data, otherwise as 03H
// - 3BH adds eight dummy clocks then outputs on both lanes
// - Dual address input takes every bit on lane zero
// - Security addresses use 00H, 1H or 2H, 0000b, offset
// - Dual data: lane zero even bits, lane one odd bits
// - Simple commands need a clock count multiple of eight
`timescale 1ns/1ns
`include "sfcrs_map.vh"
module sfcrs_top #(
	parameter TW_CYC = `SFCRS_TW_CYC
) (
	// Clock and reset
	input wire clk_i,
	input wire srst_i,
	// Serial link pins
	input wire sclk_i,
	input wire sel_n_i,
	input wire lane_zero_i,
	output reg lane_zero_o,
	output reg lane_zero_oe_n_o,
	input wire lane_one_i,
	output reg lane_one_o,
	output reg lane_one_oe_n_o,
	input wire protect_n_i,
	// Stored non-volatile status image
	input wire [15:0] nv_status_i,
	output reg [15:0] nv_status_o,
	output reg nv_write_o,
	// Array fetch port
	output reg [23:0] arr_addr_o,
	output reg arr_req_o,
	input wire arr_ack_i,
	input wire [7:0] arr_data_i,
	// Security access decode
	output reg sec_sel_o,
	output reg [1:0] sec_reg_o,
	// Visible status
	output reg [15:0] status_o
);
	// ---------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------
	reg [2:0] s_clk;
	reg [2:0] s_sel;
	reg [2:0] s_d0;
	reg [2:0] s_d1;
	reg [2:0] s_wp;
	reg clk_q;
	reg sel_q;
	// Three stages; a change counts once stages two and three agree
	always @(posedge clk_i) begin
		if (srst_i) begin
			s_clk <= 3'b000;
			s_sel <= 3'b111;
			s_d0 <= 3'b000;
			s_d1 <= 3'b000;
			s_wp <= 3'b111;
			clk_q <= 1'b0;
			sel_q <= 1'b1;
		end else begin
			s_clk <= {s_clk[1:0], sclk_i};
			s_sel <= {s_sel[1:0], sel_n_i};
			s_d0 <= {s_d0[1:0], lane_zero_i};
			s_d1 <= {s_d1[1:0], lane_one_i};
			s_wp <= {s_wp[1:0], protect_n_i};
			if (s_clk[1] == s_clk[2])
				clk_q <= s_clk[2];
			if (s_sel[1] == s_sel[2])
				sel_q <= s_sel[2];
		end
	end
	wire rise = s_clk[1] & s_clk[2] & ~clk_q;
	wire fall = ~s_clk[1] & ~s_clk[2] & clk_q;
	wire sel_up = s_sel[1] & s_sel[2] & ~sel_q;
	wire active = ~sel_q;

	// ---------------------------------------------
	// Frame state
	// ---------------------------------------------
	localparam ST_OP = 3'd0;
	localparam ST_ADDR = 3'd1;
	localparam ST_DUMMY = 3'd2;
	localparam ST_DATA = 3'd3;
	localparam ST_SRIN = 3'd4;
	localparam ST_IDLE = 3'd5;
	reg [2:0] state;
	reg [7:0] opc;
	reg [7:0] shin;
	reg [4:0] bitcnt;
	reg [23:0] addr;
	reg [7:0] shout;
	reg [3:0] outcnt;
	reg [15:0] srin;
	reg [4:0] srbits;
	reg [15:0] vstat;
	reg wl;
	reg vol_arm;
	reg vol_use;
	reg busy;
	reg [31:0] tcnt;
	reg [15:0] pend;
	reg pend_vol;
	reg first_out;
	reg boot;
	// Buffer between fetch and shifter
	wire bf_ready;
	wire bf_valid;
	wire [7:0] bf_data;
	reg bf_take;
	wire dual = (opc == `SFCRS_OP_DUAL);
	wire is_sr = (opc == `SFCRS_OP_RD_SR1) || (opc == `SFCRS_OP_RD_SR2);
	wire [7:0] nxt_in = {shin[6:0], s_d0[2]};
	wire locked = vstat[`SFCRS_SR_LOCK0] & ~s_wp[2];
	wire [4:0] dlen = dual ? 5'd4 : 5'd8;
	wire [15:0] status = {vstat[15:2], wl, busy};

	sfcrs_buf2 u_buf (
		.clk_i(clk_i),
		.srst_i(srst_i | sel_up),
		.in_valid_i(arr_ack_i),
		.in_ready_o(bf_ready),
		.in_data_i(arr_data_i),
		.out_valid_o(bf_valid),
		.out_ready_i(bf_take),
		.out_data_o(bf_data)
	);

	// ---------------------------------------------
	// Command engine
	// ---------------------------------------------
	// One clocked process owns all shared state, so flags have one driver
	always @(posedge clk_i) begin
		if (srst_i) begin
			state <= ST_OP;
			opc <= 8'h00;
			shin <= 8'h00;
			bitcnt <= 5'd0;
			addr <= 24'h00_0000;
			shout <= 8'h00;
			outcnt <= 4'd0;
			srin <= 16'h0000;
			srbits <= 5'd0;
			vstat <= `SFCRS_SR_RESET;
			wl <= 1'b0;
			vol_arm <= 1'b0;
			vol_use <= 1'b0;
			busy <= 1'b0;
			tcnt <= 32'h0000_0000;
			pend <= 16'h0000;
			pend_vol <= 1'b0;
			first_out <= 1'b0;
			boot <= 1'b1;
			bf_take <= 1'b0;
			arr_req_o <= 1'b0;
			arr_addr_o <= 24'h00_0000;
			nv_status_o <= 16'h0000;
			nv_write_o <= 1'b0;
		end else begin
			bf_take <= 1'b0;
			nv_write_o <= 1'b0;
			// copy stored bits after reset release
			if (boot) begin
				boot <= 1'b0;
				vstat <= nv_status_i & 16'hFFFC;
			end
			// self-timed cycle, then busy and latch clear
			if (busy) begin
				if (tcnt == 32'h0000_0000) begin
					busy <= 1'b0;
					wl <= 1'b0;
					vstat <= pend;
					if (!pend_vol) begin
						nv_status_o <= pend;
						nv_write_o <= 1'b1;
					end
				end else
					tcnt <= tcnt - 32'h0000_0001;
			end
			if (arr_ack_i)
				arr_req_o <= 1'b0;
			if (active && rise) begin
				bitcnt <= bitcnt + 5'd1;
				case (state)
				ST_OP: begin
					shin <= nxt_in;
					if (bitcnt == 5'd7) begin
						opc <= nxt_in;
						bitcnt <= 5'd0;
						vol_use <= vol_arm;
						vol_arm <= 1'b0;
						case (nxt_in)
						`SFCRS_OP_READ, `SFCRS_OP_FAST, `SFCRS_OP_DUAL:
							state <= busy ? ST_IDLE : ST_ADDR;
						`SFCRS_OP_RD_SR1, `SFCRS_OP_RD_SR2: begin
							state <= ST_DATA;
							first_out <= 1'b1;
						end
						`SFCRS_OP_WR_SR, `SFCRS_OP_WR_SR2: begin
							state <= ST_SRIN;
							srbits <= 5'd0;
						end
						default:
							state <= ST_IDLE;
						endcase
					end
				end
				ST_ADDR: begin
					// address bits taken on rising edges
					addr <= {addr[22:0], s_d0[2]};
					if (bitcnt == 5'd23) begin
						bitcnt <= 5'd0;
						if (opc == `SFCRS_OP_READ) begin
							state <= ST_DATA;
							arr_req_o <= 1'b1;
							arr_addr_o <= {addr[22:0], s_d0[2]};
							first_out <= 1'b1;
						end else
							state <= ST_DUMMY;
					end
				end
				ST_DUMMY: begin
					if (bitcnt == 5'd7) begin
						state <= ST_DATA;
						arr_req_o <= 1'b1;
						arr_addr_o <= addr;
						first_out <= 1'b1;
					end
				end
				ST_SRIN: begin
					srin <= {srin[14:0], s_d0[2]};
					srbits <= srbits + 5'd1;
				end
				default: ;
				endcase
			end
			// Output shifting on falling edges
			if (active && fall && state == ST_DATA) begin
				if (first_out || outcnt == 4'd0) begin
					first_out <= 1'b0;
					outcnt <= dlen[3:0] - 4'd1;
					if (is_sr) begin
						shout <= (opc == `SFCRS_OP_RD_SR1) ?
							status[7:0] : status[15:8];
					end else begin
						shout <= bf_data;
						bf_take <= 1'b1;
						addr <= (arr_addr_o == `SFCRS_ADDR_MAX) ?
							24'h00_0000 : arr_addr_o + 24'h00_0001;
						arr_addr_o <= (arr_addr_o == `SFCRS_ADDR_MAX) ?
							24'h00_0000 : arr_addr_o + 24'h00_0001;
						arr_req_o <= 1'b1;
					end
				end else begin
					outcnt <= outcnt - 4'd1;
					shout <= dual ? {shout[5:0], 2'b00} :
						{shout[6:0], 1'b0};
				end
			end
			// Frame end: decode clean-boundary commands
			if (sel_up) begin
				state <= ST_OP;
				bitcnt <= 5'd0;
				arr_req_o <= 1'b0;
				if (bitcnt[2:0] == 3'd0 && state == ST_IDLE && !busy) begin
					if (opc == `SFCRS_OP_SET_WL)
						wl <= 1'b1;
					if (opc == `SFCRS_OP_CLR_WL)
						wl <= 1'b0;
					if (opc == `SFCRS_OP_VOL_WE)
						vol_arm <= 1'b1;
				end
				if (state == ST_SRIN && !busy && !locked &&
					(wl || vol_use) && (srbits == 5'd8 ||
					(srbits == 5'd16 && opc == `SFCRS_OP_WR_SR))) begin
					busy <= 1'b1;
					tcnt <= vol_use ? 32'h0000_0000 : TW_CYC - 1;
					pend_vol <= vol_use;
					if (opc == `SFCRS_OP_WR_SR2)
						pend <= (vstat & ~`SFCRS_SR_WMASK) |
							({srin[7:0], 8'h00} & `SFCRS_SR_WMASK);
					else if (srbits == 5'd8)
						pend <= (vstat & ~`SFCRS_SR_WMASK) |
							({8'h00, srin[7:0]} &
							`SFCRS_SR_WMASK & 16'h00FF);
					else
						pend <= (vstat & ~`SFCRS_SR_WMASK) |
							({srin[7:0], srin[15:8]} &
							`SFCRS_SR_WMASK);
				end
				vol_use <= 1'b0;
			end
		end
	end

	// ---------------------------------------------
	// Pin drive and visible status
	// ---------------------------------------------
	// Enables are active low; released whenever no output phase runs
	always @(posedge clk_i) begin
		if (srst_i) begin
			lane_zero_o <= 1'b0;
			lane_zero_oe_n_o <= 1'b1;
			lane_one_o <= 1'b0;
			lane_one_oe_n_o <= 1'b1;
			status_o <= 16'h0000;
			sec_sel_o <= 1'b0;
			sec_reg_o <= 2'd0;
		end else begin
			status_o <= status;
			sec_sel_o <= (arr_addr_o[23:16] == 8'h00) &&
				(arr_addr_o[11:8] == 4'h0) &&
				(arr_addr_o[15:12] == 4'h1 ||
				arr_addr_o[15:12] == 4'h2);
			sec_reg_o <= arr_addr_o[13:12];
			if (!active || state != ST_DATA || first_out) begin
				lane_zero_oe_n_o <= 1'b1;
				lane_one_oe_n_o <= 1'b1;
			end else if (dual) begin
				// even bits lane zero, odd lane one
				lane_one_o <= shout[7];
				lane_zero_o <= shout[6];
				lane_one_oe_n_o <= 1'b0;
				lane_zero_oe_n_o <= 1'b0;
			end else begin
				lane_one_o <= shout[7];
				lane_one_oe_n_o <= 1'b0;
				lane_zero_oe_n_o <= 1'b1;
			end
		end
	end
endmodule

// ### verilog/sfcrs_map.vh
`ifndef SFCRS_MAP_VH
`define SFCRS_MAP_VH
// ---------------------------------------------
// Opcodes
// ---------------------------------------------
`define SFCRS_OP_SET_WL 8'h06
`define SFCRS_OP_CLR_WL 8'h04
`define SFCRS_OP_VOL_WE 8'h50
`define SFCRS_OP_RD_SR1 8'h05
`define SFCRS_OP_RD_SR2 8'h35
`define SFCRS_OP_WR_SR 8'h01
`define SFCRS_OP_WR_SR2 8'h31
`define SFCRS_OP_READ 8'h03
`define SFCRS_OP_FAST 8'h0B
`define SFCRS_OP_DUAL 8'h3B
// ---------------------------------------------
// Status fields
// ---------------------------------------------
`define SFCRS_SR_BUSY 0
`define SFCRS_SR_WL 1
`define SFCRS_SR_LOCK0 7
`define SFCRS_SR_LOCK1 8
// Writable bits: 12..11, 7, 4..2
`define SFCRS_SR_WMASK 16'h189C
`define SFCRS_SR_RESET 16'h0000
// ---------------------------------------------
// Timing
// ---------------------------------------------
`define SFCRS_CLK_MHZ 125
`define SFCRS_TW_US 5000
`define SFCRS_TW_CYC (`SFCRS_TW_US * `SFCRS_CLK_MHZ)
`define SFCRS_ADDR_MAX 24'h07_FFFF
`endif

// ### verilog/sfcrs_buf2.v
`timescale 1ns/1ns
// Two-entry buffer; a stalled drain never loses a word
module sfcrs_buf2 (
	// Clock and reset
	input wire clk_i,
	input wire srst_i,
	// Fill side
	input wire in_valid_i,
	output wire in_ready_o,
	input wire [7:0] in_data_i,
	// Drain side
	output wire out_valid_o,
	input wire out_ready_i,
	output wire [7:0] out_data_o
);
	reg [7:0] mem [0:1];
	reg wp;
	reg rp;
	reg [1:0] cnt;
	wire push;
	wire pop;

	assign in_ready_o = (cnt != 2'd2);
	assign out_valid_o = (cnt != 2'd0);
	assign out_data_o = mem[rp];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	// Pointers and occupancy
	always @(posedge clk_i) begin
		if (srst_i) begin
			wp <= 1'b0;
			rp <= 1'b0;
			cnt <= 2'd0;
		end else begin
			if (push) begin
				mem[wp] <= in_data_i;
				wp <= ~wp;
			end
			if (pop)
				rp <= ~rp;
			if (push && !pop)
				cnt <= cnt + 2'd1;
			else if (pop && !push)
				cnt <= cnt - 2'd1;
		end
	end
endmodule

// ### tb/sfcrs_host.sv
`timescale 1ns/1ns
// ------------------------------------
// Link host: the clock rests low between frames
// ------------------------------------
module sfcrs_host (
	// Link outputs
	output reg sclk_o,
	output reg sel_n_o,
	output reg mosi_o,
	output reg mosi_oe_n_o,
	// Link inputs
	input wire lane_zero_i,
	input wire lane_one_i
);
	// Idle pins
	initial begin
		sclk_o = 0;
		sel_n_o = 1;
		mosi_o = 0;
		mosi_oe_n_o = 0;
	end
	// Open a frame
	task start;
	begin
		#40 sel_n_o = 0;
		#80;
	end
	endtask
	task xfer(input [7:0] tx, input integer nb, input dual,
		output [7:0] rx);
	integer i;
	begin
		rx = 8'h00;
		for (i = nb - 1; i >= 0; i = i - 1) begin
			if (!dual)
				mosi_o = tx[i];
			#40 sclk_o = 1;
			#32;
			if (dual)
				rx = {rx[5:0], lane_one_i, lane_zero_i};
			else
				rx = {rx[6:0], lane_one_i};
			#8 sclk_o = 0;
		end
	end
	endtask
	// end on count given
	// Released input toggles so a stale level cannot pass
	task stop;
	begin
		#40 sel_n_o = 1;
		mosi_oe_n_o = 0;
		mosi_o = ~mosi_o;
		#160;
	end
	endtask
endmodule

// ### tb/sfcrs_top_properties.sv
`timescale 1ns/1ns
`include "sfcrs_map.vh"
// ------------------------------------
// Checker
// ------------------------------------
module sfcrs_chk (
	// Clock and reset
	input wire clk_i,
	input wire srst_i,
	// Pins
	input wire sel_n_i,
	input wire lane_zero_oe_n_o,
	input wire lane_one_oe_n_o,
	// Fetch and status
	input wire nv_write_o,
	input wire [23:0] arr_addr_o,
	input wire arr_req_o,
	input wire arr_ack_i,
	input wire sec_sel_o,
	input wire [15:0] status_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	AST_OE_IDLE: assert property (
		sel_n_i [*8] |-> lane_zero_oe_n_o && lane_one_oe_n_o)
		else $error("pins driven while deselected");
	AST_BUSY_NO_READ: assert property (
		status_o[0] |-> !$rose(arr_req_o))
		else $error("fetch started while busy");
	AST_FLAGS_CLR: assert property (
		$fell(status_o[0]) |-> !status_o[1])
		else $error("latch left set after write cycle");
	AST_WL_AT_END: assert property (
		$rose(status_o[1]) |-> sel_n_i && $past(sel_n_i, 2))
		else $error("latch set inside a frame");
	AST_NV_PULSE: assert property (
		nv_write_o |=> !nv_write_o)
		else $error("store strobe longer than one cycle");
	// Fixed bits may only move at the load after reset
	AST_FIXED_BITS: assert property (
		!$past(srst_i) && !$past(srst_i, 2) && !$past(srst_i, 3) |->
		$stable(status_o & ~(`SFCRS_SR_WMASK | 16'h0003)))
		else $error("fixed status bit changed");
	AST_REQ_HOLD: assert property (
		arr_req_o && !arr_ack_i && !sel_n_i |=>
		arr_req_o && $stable(arr_addr_o))
		else $error("fetch request dropped or moved");
	AST_SEC_DEC: assert property (
		sec_sel_o && $stable(arr_addr_o) |-> arr_addr_o[23:16] == 8'h00
		&& arr_addr_o[11:8] == 4'h0 && (arr_addr_o[15:12] == 4'h1
		|| arr_addr_o[15:12] == 4'h2))
		else $error("security decode on a plain address");
	AST_DUAL_OE: assert property (
		!lane_zero_oe_n_o |-> !lane_one_oe_n_o)
		else $error("lane zero driven alone");
endmodule
bind sfcrs_top sfcrs_chk chk_u (.clk_i(clk_i), .srst_i(srst_i),
	.sel_n_i(sel_n_i), .lane_zero_oe_n_o(lane_zero_oe_n_o),
	.lane_one_oe_n_o(lane_one_oe_n_o), .nv_write_o(nv_write_o),
	.arr_addr_o(arr_addr_o), .arr_req_o(arr_req_o),
	.arr_ack_i(arr_ack_i), .sec_sel_o(sec_sel_o), .status_o(status_o));

// ### tb/sfcrs_top_test.sv
`timescale 1ns/1ns
`include "sfcrs_map.vh"
// ------------------------------------
// Bench
// ------------------------------------
module sfcrs_top_test;
	localparam NV = 16'h2020;
	reg clk = 0;
	reg srst = 1;
	reg protect_n = 1;
	reg arr_ack = 0;
	reg arr_wait = 0;
	integer n_nvw = 0;
	reg [7:0] arr_data = 8'h00;
	wire sclk, sel_n, mosi, mosi_oe_n, l0, l1, l0_o, l0_oe_n, l1_o, l1_oe_n;
	wire arr_req, sec_sel, nvw;
	wire [15:0] status, nvo;
	wire [23:0] arr_addr;
	wire [1:0] sec_reg;
	integer n_fail = 0;
	integer check_count = 0;
	integer cyc = 0;
	integer n_req = 0;
	reg [15:0] sr = NV;
	reg [7:0] r;
	// Released lane one shows the inverse of its last value; lane zero shows mosi, inverted while the host releases it
	assign l0 = !l0_oe_n ? l0_o : mosi ^ mosi_oe_n;
	assign l1 = !l1_oe_n ? l1_o : ~l1_o;
	sfcrs_host host_u (.sclk_o(sclk), .sel_n_o(sel_n), .mosi_o(mosi),
		.mosi_oe_n_o(mosi_oe_n), .lane_zero_i(l0), .lane_one_i(l1));
	sfcrs_top #(.TW_CYC(1000)) dut_u (.clk_i(clk), .srst_i(srst),
		.sclk_i(sclk), .sel_n_i(sel_n), .lane_zero_i(l0),
		.lane_zero_o(l0_o), .lane_zero_oe_n_o(l0_oe_n), .lane_one_i(l1),
		.lane_one_o(l1_o), .lane_one_oe_n_o(l1_oe_n),
		.protect_n_i(protect_n), .nv_status_i(NV), .nv_status_o(nvo),
		.nv_write_o(nvw), .arr_addr_o(arr_addr), .arr_req_o(arr_req),
		.arr_ack_i(arr_ack), .arr_data_i(arr_data), .sec_sel_o(sec_sel),
		.sec_reg_o(sec_reg), .status_o(status));
	initial forever #4 clk = ~clk;
	function [7:0] fa(input [23:0] a);
		fa = a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5A;
	endfunction
	// Array answers each request once after one wait cycle
	// The request count exposes refused reads
	always @(negedge clk) begin
		arr_wait <= arr_req & ~arr_ack & ~arr_wait;
		arr_ack <= arr_wait & arr_req;
		arr_data <= fa(arr_addr);
		if (arr_req && !arr_ack && !arr_wait)
			n_req <= n_req + 1;
		if (nvw)
			n_nvw <= n_nvw + 1;
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_fail = n_fail + 1;
			test_done;
		end
	end
	task chk(input [63:0] nm, input [15:0] exp, input [15:0] got);
	begin
		check_count = check_count + 1;
		if (got !== exp) begin
			n_fail = n_fail + 1;
			$display("BAD %0s exp %h got %h", nm, exp, got);
		end
	end
	endtask
	task wt;
	integer i;
	begin
		for (i = 0; i < 2000 && status[0] !== 1'b0; i = i + 1)
			@(negedge clk);
	end
	endtask
	task cmd(input [7:0] op, input [7:0] d0, input [7:0] d1,
		input integer n);
	begin
		host_u.start;
		host_u.xfer(op, 8, 1'b0, r);
		if (n > 0)
			host_u.xfer(d0, 8, 1'b0, r);
		if (n > 1)
			host_u.xfer(d1, 8, 1'b0, r);
		host_u.stop;
	end
	endtask
	// Status read over the link, two repeats of one byte
	task srd(input [7:0] op, input [7:0] exp, input [7:0] m);
	begin
		host_u.start;
		host_u.xfer(op, 8, 1'b0, r);
		repeat (2) begin
			host_u.xfer(8'h00, 8, 1'b0, r);
			chk("sread", {8'h00, exp & m}, {8'h00, r & m});
		end
		host_u.stop;
	end
	endtask
	task rd(input [7:0] op, input [23:0] a, input dum, input dual,
		input on);
	integer k;
	begin
		host_u.start;
		host_u.xfer(op, 8, 1'b0, r);
		for (k = 2; k >= 0; k = k - 1)
			host_u.xfer(a[8*k+:8], 8, 1'b0, r);
		if (dual)
			host_u.mosi_oe_n_o = 1;
		if (dum)
			host_u.xfer(8'h00, 8, 1'b0, r);
		for (k = 0; k < 2; k = k + 1) begin
			host_u.xfer(8'h00, dual ? 4 : 8, dual, r);
			if (on)
				chk("rdata", {8'h00, fa(a)}, {8'h00, r});
			a = (a == `SFCRS_ADDR_MAX) ? 24'h00_0000 : a + 1;
		end
		host_u.stop;
	end
	endtask
	task wr(input [15:0] v);
	begin
		wt;
		sr = (sr & ~`SFCRS_SR_WMASK) | (v & `SFCRS_SR_WMASK);
		chk("status", sr, status);
	end
	endtask
	task t_latch;
	begin
		chk("reset", NV, status);
		cmd(`SFCRS_OP_SET_WL, 0, 0, 0);
		chk("wl_set", 16'h0002, status & 16'h0003);
		srd(`SFCRS_OP_RD_SR1, {sr[7:2], 2'b10}, 8'hFF);
		srd(`SFCRS_OP_RD_SR2, sr[15:8], 8'hFF);
		cmd(`SFCRS_OP_CLR_WL, 0, 0, 0);
		chk("wl_clr", 16'h0000, status & 16'h0003);
		host_u.start;
		host_u.xfer(`SFCRS_OP_SET_WL, 8, 1'b0, r);
		host_u.xfer(8'h00, 1, 1'b0, r);
		host_u.stop;
		chk("wl_odd", 16'h0000, status & 16'h0003);
	end
	endtask
	task t_status_write_cmd;
	integer q;
	begin
		cmd(`SFCRS_OP_WR_SR, 8'h00, 8'hFF, 2);
		chk("no_wl", sr, status);
		cmd(`SFCRS_OP_SET_WL, 0, 0, 0);
		cmd(`SFCRS_OP_WR_SR, 8'h00, 8'hFF, 2);
		chk("busy", 16'h0001, status & 16'h0001);
		q = n_req;
		rd(`SFCRS_OP_READ, 24'h00_0010, 1'b0, 1'b0, 1'b0);
		chk("refused", q, n_req);
		srd(`SFCRS_OP_RD_SR1, 8'h03, 8'h03);
		wr(16'hFF00);
		chk("nv_data", sr, nvo);
		cmd(`SFCRS_OP_SET_WL, 0, 0, 0);
		host_u.start;
		host_u.xfer(`SFCRS_OP_WR_SR, 8, 1'b0, r);
		host_u.xfer(8'hFF, 8, 1'b0, r);
		host_u.xfer(8'hFF, 4, 1'b0, r);
		host_u.stop;
		chk("odd_len", sr, status & 16'hFFFC);
		cmd(`SFCRS_OP_WR_SR2, 8'h00, 0, 1);
		wr({8'h00, sr[7:0]});
	end
	endtask
	task t_lock;
	integer q;
	begin
		cmd(`SFCRS_OP_SET_WL, 0, 0, 0);
		cmd(`SFCRS_OP_WR_SR, 8'h80, 0, 1);
		wr({sr[15:8], 8'h80});
		protect_n = 0;
		cmd(`SFCRS_OP_SET_WL, 0, 0, 0);
		cmd(`SFCRS_OP_WR_SR, 8'h00, 0, 1);
		wt;
		chk("locked", sr, status & 16'hFFFC);
		protect_n = 1;
		cmd(`SFCRS_OP_CLR_WL, 0, 0, 0);
		cmd(`SFCRS_OP_VOL_WE, 0, 0, 0);
		chk("vol_wl", 16'h0000, status & 16'h0002);
		q = n_nvw;
		cmd(`SFCRS_OP_WR_SR, 8'h00, 0, 1);
		wr({sr[15:8], 8'h00});
		chk("nv_keep", q, n_nvw);
	end
	endtask
	task t_read;
	begin
		rd(`SFCRS_OP_READ, `SFCRS_ADDR_MAX, 1'b0, 1'b0, 1'b1);
		rd(`SFCRS_OP_FAST, 24'h00_1005, 1'b1, 1'b0, 1'b1);
		chk("sec", 16'h0001, {15'h0000, sec_sel});
		chk("sec_reg", 16'h0001, {14'h0000, sec_reg});
		rd(`SFCRS_OP_DUAL, 24'h00_0123, 1'b1, 1'b1, 1'b1);
		chk("oe_idle", 16'h0003, {14'h0000, l1_oe_n, l0_oe_n});
	end
	endtask
	task test_done;
	begin
		$display("checks %0d fails %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	end
	endtask
	// Main sequence
	initial begin
		repeat (16) @(negedge clk);
		srst = 0;
		repeat (8) @(negedge clk);
		t_latch;
		t_status_write_cmd;
		t_lock;
		t_read;
		test_done;
	end
endmodule
